//--- design/crossbar_pkg.sv
// Constants, field layout and carriers for the dual MII port crossbar.
// Assumes a single 125 MHz core clock and 16-bit management registers.
package crossbar_pkg;
    // ********************************
    // Register offsets and fields
    // ********************************
    localparam logic [4:0] REG_BASIC = 5'h00;
    localparam logic [4:0] REG_PORT_MAP = 5'h17;
    localparam int ISOLATE_BIT = 10;
    localparam int DUAL_WRITE_BIT = 15;
    localparam int RX_MAP_LO = 11;
    localparam int TX_MAP_LO = 9;
    localparam int SC_RX_BIT = 7;
    localparam int SC_TX_BIT = 6;
    localparam int RMII_BIT = 5;
    localparam logic [15:0] BASIC_RST = 16'h0000;
    localparam logic [15:0] PORT_MAP_RST = 16'h0000;
    localparam logic [3:0] EXT_MAP = 4'hE;
    localparam logic [3:0] PORT_OFF_MAP = 4'hF;
    // ********************************
    // Mapping codes
    // ********************************
    localparam logic [1:0] MAP_OWN = 2'h0;
    localparam logic [1:0] MAP_OPP = 2'h1;
    localparam logic [1:0] MAP_XRX = 2'h2;
    localparam logic [1:0] MAP_OFF = 2'h3;
    localparam logic [1:0] PICK_OWN = 2'h0;
    localparam logic [1:0] PICK_OTHER = 2'h1;
    localparam logic [1:0] PICK_NONE = 2'h2;
    // ********************************
    // Management frame and timing
    // ********************************
    localparam logic [5:0] PREAMBLE_LAST = 6'h1F;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [3:0] ADDR_LAST = 4'h9;
    localparam logic [3:0] DATA_LAST = 4'hF;
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [4:0] PHY_BASE = 5'h01;
    localparam int SYNC_W = 20;
    // ********************************
    // Types
    // ********************************
    typedef struct packed {
        logic valid;
        logic en;
        logic [3:0] data;
    } mii_word_s;
    typedef enum logic [5:0] {
        ST_PRE = 6'h01,
        ST_START = 6'h02,
        ST_OP = 6'h04,
        ST_ADDR = 6'h08,
        ST_TURN = 6'h10,
        ST_DATA = 6'h20
    } mgmt_e;
endpackage

//--- design/port_crossbar.sv
// Dual channel MII port crossbar with serial management registers.
// Assumes MAC pins, straps and MDC/MDIO are asynchronous to i_mclk.
`timescale 1ns/1ns
`default_nettype none
module port_crossbar (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_mdc,
    input wire logic i_mdio,
    output logic o_mdio,
    output logic o_mdio_oe_n,
    input wire crossbar_pkg::mii_word_s [1:0] i_port_tx,
    output crossbar_pkg::mii_word_s [1:0] o_port_rx,
    output logic [1:0] o_port_crs,
    output logic [1:0] o_port_col,
    output logic [1:0] o_port_oe_n,
    input wire crossbar_pkg::mii_word_s [1:0] i_chan_rx,
    input wire logic [1:0] i_chan_crs,
    input wire logic [1:0] i_chan_col,
    input wire logic [1:0] i_chan_pwr_down,
    input wire logic [1:0] i_chan_energy_idle,
    input wire logic [1:0] i_chan_link,
    output crossbar_pkg::mii_word_s [1:0] o_chan_tx,
    input wire logic [1:0] i_chan_tx_ready,
    output logic [1:0] o_chan_src_ready,
    output logic [1:0] o_chan_jam,
    output logic [1:0] o_link_indicator,
    input wire logic i_extender_strap,
    input wire logic i_rmii_strap,
    input wire logic [1:0] i_autoneg_strap,
    input wire logic [1:0] i_fiber_mode_strap,
    output logic [1:0] o_chan_autoneg,
    output logic [1:0] o_chan_fiber,
    output logic [1:0][15:0] o_chan_basic,
    output logic [1:0][15:0] o_chan_port_map
);
    // ********************************
    // Reset release and pin sync
    // ********************************
    logic rst_meta;
    logic rst_n;
    logic [crossbar_pkg::SYNC_W-1:0] sync_meta;
    logic [crossbar_pkg::SYNC_W-1:0] sync_q;
    logic mdc_q;
    logic mdio_q;
    logic ext_q;
    logic rmii_q;
    logic [1:0] an_q;
    logic [1:0] fx_q;
    crossbar_pkg::mii_word_s [1:0] port_tx_q;

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            sync_meta <= '0;
            sync_q <= '0;
        end else begin
            sync_meta <= {i_mdc, i_mdio, i_port_tx, i_extender_strap,
                i_rmii_strap, i_autoneg_strap, i_fiber_mode_strap};
            sync_q <= sync_meta;
        end
    end

    assign {mdc_q, mdio_q, port_tx_q, ext_q, rmii_q, an_q, fx_q} = sync_q;

    // ********************************
    // Management bit engine
    // ********************************
    // MDC is only sampled, so it must stay well below i_mclk / 4
    crossbar_pkg::mgmt_e state;
    logic mdc_last;
    logic mdc_rise;
    logic [5:0] ones;
    logic synced;
    logic [3:0] bit_cnt;
    logic [1:0] op;
    logic [9:0] addr_sr;
    logic [15:0] data_sr;
    logic reading;
    logic wr_stb;
    logic [9:0] wr_addr;
    logic [15:0] wr_data;
    logic [1:0][15:0] basic;
    logic [1:0][15:0] port_map;
    logic [9:0] next_addr;

    assign mdc_rise = mdc_q & ~mdc_last;
    assign next_addr = {addr_sr[8:0], mdio_q};

    function automatic logic [1:0] phy_hit(input logic [4:0] phy);
        phy_hit[0] = (phy == crossbar_pkg::PHY_BASE);
        phy_hit[1] = (phy == crossbar_pkg::PHY_BASE + 5'h01);
    endfunction

    function automatic logic [15:0] reg_read(input logic [9:0] a,
            input logic [1:0][15:0] b, input logic [1:0][15:0] m);
        logic [1:0] hit;
        logic ch;
        hit = phy_hit(a[9:5]);
        ch = hit[1];
        unique case (a[4:0])
            crossbar_pkg::REG_BASIC: reg_read = b[ch];
            crossbar_pkg::REG_PORT_MAP: reg_read = m[ch];
            default: reg_read = 16'h0000;
        endcase
    endfunction

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_last <= 1'b0;
        end else begin
            mdc_last <= mdc_q;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= crossbar_pkg::ST_PRE;
            ones <= 6'h00;
            synced <= 1'b0;
            bit_cnt <= 4'h0;
            op <= 2'h0;
            addr_sr <= 10'h000;
            data_sr <= 16'h0000;
            reading <= 1'b0;
            o_mdio <= 1'b1;
            o_mdio_oe_n <= 1'b1;
            wr_stb <= 1'b0;
            wr_addr <= 10'h000;
            wr_data <= 16'h0000;
        end else begin
            wr_stb <= 1'b0;
            if (mdc_rise) begin
                unique case (state)
                    crossbar_pkg::ST_PRE: begin
                        if (mdio_q) begin
                            if (ones != crossbar_pkg::PREAMBLE_LAST) begin
                                ones <= ones + 6'h01;
                            end else begin
                                synced <= 1'b1;
                            end
                        end else if (synced) begin
                            state <= crossbar_pkg::ST_START;
                        end else begin
                            ones <= 6'h00;
                        end
                    end
                    crossbar_pkg::ST_START: begin
                        if (mdio_q) begin
                            state <= crossbar_pkg::ST_OP;
                            bit_cnt <= 4'h0;
                        end else begin
                            synced <= 1'b0;
                            ones <= 6'h00;
                            state <= crossbar_pkg::ST_PRE;
                        end
                    end
                    crossbar_pkg::ST_OP: begin
                        op <= {op[0], mdio_q};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h1) begin
                            bit_cnt <= 4'h0;
                            if ({op[0], mdio_q} == crossbar_pkg::OP_READ ||
                                    {op[0], mdio_q} == crossbar_pkg::OP_WRITE)
                                    begin
                                state <= crossbar_pkg::ST_ADDR;
                            end else begin
                                synced <= 1'b0;
                                ones <= 6'h00;
                                state <= crossbar_pkg::ST_PRE;
                            end
                        end
                    end
                    crossbar_pkg::ST_ADDR: begin
                        addr_sr <= next_addr;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == crossbar_pkg::ADDR_LAST) begin
                            bit_cnt <= 4'h0;
                            state <= crossbar_pkg::ST_TURN;
                            reading <= (op == crossbar_pkg::OP_READ) &&
                                (phy_hit(next_addr[9:5]) != 2'h0);
                            data_sr <= reg_read(next_addr, basic, port_map);
                        end
                    end
                    crossbar_pkg::ST_TURN: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == 4'h0) begin
                            if (reading) begin
                                o_mdio <= 1'b0;
                                o_mdio_oe_n <= 1'b0;
                            end
                            if (op == crossbar_pkg::OP_WRITE && !mdio_q) begin
                                synced <= 1'b0;
                                ones <= 6'h00;
                                state <= crossbar_pkg::ST_PRE;
                            end
                        end else begin
                            bit_cnt <= 4'h0;
                            state <= crossbar_pkg::ST_DATA;
                            o_mdio <= data_sr[15];
                            data_sr <= {data_sr[14:0], 1'b0};
                        end
                    end
                    crossbar_pkg::ST_DATA: begin
                        bit_cnt <= bit_cnt + 4'h1;
                        if (reading) begin
                            o_mdio <= data_sr[15];
                            data_sr <= {data_sr[14:0], 1'b0};
                        end else begin
                            data_sr <= {data_sr[14:0], mdio_q};
                        end
                        if (bit_cnt == crossbar_pkg::DATA_LAST) begin
                            o_mdio <= 1'b1;
                            o_mdio_oe_n <= 1'b1;
                            ones <= 6'h00;
                            state <= crossbar_pkg::ST_PRE;
                            wr_stb <= (op == crossbar_pkg::OP_WRITE);
                            wr_addr <= addr_sr;
                            wr_data <= {data_sr[14:0], mdio_q};
                        end
                    end
                    default: begin
                        state <= crossbar_pkg::ST_PRE;
                    end
                endcase
            end
        end
    end

    // ********************************
    // Channel registers and straps
    // ********************************
    // Straps are taken a few cycles after reset release, after the sync
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] wr_hit;

    always_comb begin
        wr_hit = phy_hit(wr_addr[9:5]);
        if (wr_hit[0] && port_map[0][crossbar_pkg::DUAL_WRITE_BIT]) begin
            wr_hit = 2'h3;
        end
    end

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            basic <= {crossbar_pkg::BASIC_RST, crossbar_pkg::BASIC_RST};
            port_map <= {crossbar_pkg::PORT_MAP_RST,
                crossbar_pkg::PORT_MAP_RST};
            o_chan_autoneg <= 2'h0;
            o_chan_fiber <= 2'h0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            if (strap_cnt == crossbar_pkg::STRAP_WAIT) begin
                strap_done <= 1'b1;
                o_chan_autoneg <= an_q;
                o_chan_fiber <= fx_q;
                for (int c = 0; c < 2; c++) begin
                    port_map[c][crossbar_pkg::RMII_BIT] <= rmii_q;
                    if (ext_q) begin
                        port_map[c][12:9] <= crossbar_pkg::EXT_MAP;
                        port_map[c][crossbar_pkg::SC_RX_BIT] <= !rmii_q;
                        port_map[c][crossbar_pkg::SC_TX_BIT] <= !rmii_q;
                    end
                end
            end
        end else if (wr_stb) begin
            for (int c = 0; c < 2; c++) begin
                if (wr_hit[c]) begin
                    unique case (wr_addr[4:0])
                        crossbar_pkg::REG_BASIC: basic[c] <= wr_data;
                        crossbar_pkg::REG_PORT_MAP: port_map[c] <= wr_data;
                        default: ;
                    endcase
                end
            end
        end
    end

    assign o_chan_basic = basic;
    assign o_chan_port_map = port_map;

    // ********************************
    // Receive port routing
    // ********************************
    // A channel reaches the opposite port only if its owner maps its receive as OPP or XRX
    function automatic logic [1:0] rx_pick(input logic [3:0] own_map,
            input logic [1:0] other_rx);
        logic other_wants;
        other_wants = (other_rx == crossbar_pkg::MAP_OPP) ||
            (other_rx == crossbar_pkg::MAP_XRX);
        rx_pick = crossbar_pkg::PICK_NONE;
        if (own_map == crossbar_pkg::PORT_OFF_MAP) begin
            rx_pick = crossbar_pkg::PICK_NONE;
        end else begin
            unique case (own_map[3:2])
                crossbar_pkg::MAP_OWN: rx_pick = crossbar_pkg::PICK_OWN;
                crossbar_pkg::MAP_XRX: rx_pick =
                    (other_rx == crossbar_pkg::MAP_OPP) ?
                    crossbar_pkg::PICK_OTHER : crossbar_pkg::PICK_OWN;
                crossbar_pkg::MAP_OPP: rx_pick = other_wants ?
                    crossbar_pkg::PICK_OTHER :
                    ((other_rx == crossbar_pkg::MAP_OWN) ?
                    crossbar_pkg::PICK_OWN : crossbar_pkg::PICK_NONE);
                crossbar_pkg::MAP_OFF: rx_pick = other_wants ?
                    crossbar_pkg::PICK_OTHER : crossbar_pkg::PICK_NONE;
            endcase
        end
    endfunction

    generate
        for (genvar p = 0; p < 2; p++) begin : g_port
            localparam int OTH = 1 - p;
            logic [1:0] pick;
            logic [1:0] tx_code;
            logic [1:0] oth_code;
            logic tx_crs;
            logic rx_crs;
            assign pick = rx_pick(port_map[p][12:9],
                port_map[OTH][12:11]);
            assign tx_code = port_map[p][10:9];
            assign oth_code = port_map[OTH][10:9];
            assign tx_crs = (tx_code == crossbar_pkg::MAP_OWN && i_chan_crs[p])
                || (oth_code == crossbar_pkg::MAP_OPP && i_chan_crs[OTH]);
            assign rx_crs = (pick == crossbar_pkg::PICK_OWN) ? i_chan_crs[p] :
                (pick == crossbar_pkg::PICK_OTHER) && i_chan_crs[OTH];
            always_ff @(posedge i_mclk or negedge rst_n) begin
                if (!rst_n) begin
                    o_port_rx[p] <= '0;
                    o_port_crs[p] <= 1'b0;
                    o_port_col[p] <= 1'b0;
                    o_port_oe_n[p] <= 1'b1;
                end else begin
                    o_port_rx[p] <= (pick == crossbar_pkg::PICK_OWN) ?
                        i_chan_rx[p] : ((pick == crossbar_pkg::PICK_OTHER) ?
                        i_chan_rx[OTH] : '0);
                    o_port_crs[p] <= port_map[p][crossbar_pkg::RMII_BIT] ?
                        rx_crs : tx_crs;
                    o_port_col[p] <=
                        (tx_code == crossbar_pkg::MAP_OWN && i_chan_col[p]) ||
                        (oth_code == crossbar_pkg::MAP_OPP && i_chan_col[OTH]);
                    o_port_oe_n[p] <= i_chan_pwr_down[p] |
                        i_chan_energy_idle[p] |
                        basic[p][crossbar_pkg::ISOLATE_BIT];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge rst_n) begin
        if (!rst_n) begin
            o_link_indicator <= 2'h0;
        end else begin
            o_link_indicator <= i_chan_link;
        end
    end

    // ********************************
    // Transmit source and buffering
    // ********************************
    logic bcast;
    logic sc_tx_both;

    assign bcast = port_map[0][10:9] != port_map[1][10:9] &&
        port_map[0][10:9] <= crossbar_pkg::MAP_OPP &&
        port_map[1][10:9] <= crossbar_pkg::MAP_OPP;
    assign sc_tx_both = port_map[0][crossbar_pkg::SC_TX_BIT] &&
        port_map[1][crossbar_pkg::SC_TX_BIT];

    generate
        for (genvar c = 0; c < 2; c++) begin : g_chan
            localparam int OTH = 1 - c;
            logic [1:0] code;
            crossbar_pkg::mii_word_s src;
            crossbar_pkg::mii_word_s mem [2];
            logic wr_ptr;
            logic rd_ptr;
            logic [1:0] count;
            logic push;
            logic pop;
            assign code = port_map[c][10:9];
            always_comb begin
                unique case (code)
                    crossbar_pkg::MAP_OWN: src = port_tx_q[c];
                    crossbar_pkg::MAP_OPP: src = port_tx_q[OTH];
                    crossbar_pkg::MAP_XRX: src = i_chan_rx[OTH];
                    crossbar_pkg::MAP_OFF: src = '0;
                endcase
            end
            assign o_chan_src_ready[c] = (count != 2'h2);
            assign push = src.valid && o_chan_src_ready[c];
            assign pop = (count != 2'h0) && i_chan_tx_ready[c];
            // Two entries hold the nibble of one stall cycle; push stops while count is 2, so the next nibble is lost
            always_ff @(posedge i_mclk or negedge rst_n) begin
                if (!rst_n) begin
                    wr_ptr <= 1'b0;
                    rd_ptr <= 1'b0;
                    count <= 2'h0;
                    mem[0] <= '0;
                    mem[1] <= '0;
                end else if (code == crossbar_pkg::MAP_OFF) begin
                    wr_ptr <= 1'b0;
                    rd_ptr <= 1'b0;
                    count <= 2'h0;
                end else begin
                    if (push) begin
                        mem[wr_ptr] <= src;
                        wr_ptr <= ~wr_ptr;
                    end
                    if (pop) begin
                        rd_ptr <= ~rd_ptr;
                    end
                    count <= count + {1'b0, push} - {1'b0, pop};
                end
            end
            assign o_chan_tx[c] = (count != 2'h0) ? mem[rd_ptr] : '0;
            always_ff @(posedge i_mclk or negedge rst_n) begin
                if (!rst_n) begin
                    o_chan_jam[c] <= 1'b0;
                end else begin
                    o_chan_jam[c] <= (bcast && sc_tx_both) ?
                        |i_chan_col : i_chan_col[c];
                end
            end
        end
    endgenerate
endmodule // port_crossbar
`default_nettype wire

//--- tb/crossbar_props.sv
// Checker for the port crossbar: routing, idle, jam and indicator timing.
// Assumes one core clock domain and the async active-low reset.
`timescale 1ns/1ns
`default_nettype none
module crossbar_props (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire crossbar_pkg::mii_word_s [1:0] o_port_rx,
    input wire crossbar_pkg::mii_word_s [1:0] i_chan_rx,
    input wire crossbar_pkg::mii_word_s [1:0] o_chan_tx,
    input wire logic [1:0] i_chan_col,
    input wire logic [1:0] o_chan_jam,
    input wire logic [1:0] i_chan_link,
    input wire logic [1:0] o_link_indicator,
    input wire logic [1:0][15:0] o_chan_port_map
);
    // Settle time covers the two-flop reset release
    logic [2:0] age;
    logic up;
    logic [3:0] ma, mb;
    assign ma = o_chan_port_map[0][12:9];
    assign mb = o_chan_port_map[1][12:9];
    assign up = age == 3'h7;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) age <= 3'h0;
        else if (!up) age <= age + 3'h1;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    a_rx_own: assert property (up && $past(ma) == 4'h0 && $past(mb) == 4'h0
        |-> o_port_rx == $past(i_chan_rx)) else $error("rx own path");
    a_swap_rx: assert property (up && $past(ma) == 4'h5 && $past(mb) == 4'h5
        |-> o_port_rx == {$past(i_chan_rx[0]), $past(i_chan_rx[1])})
        else $error("rx swap");
    a_ext_rx_off: assert property (up && $past(ma) == 4'hE && $past(mb) == 4'hE
        |-> o_port_rx == '0) else $error("rx not off");
    a_mirror_a: assert property (up && $past(ma[3:2]) == 2'h2
        && $past(mb[3:2]) == 2'h3 |-> o_port_rx == {2{$past(i_chan_rx[0])}})
        else $error("rx mirror");
    a_port_off: assert property (up && $past(ma) == 4'hF
        |-> o_port_rx[0] == '0) else $error("port a live");
    a_tx_idle: assert property ((up && ma[1:0] == 2'h3)[*3]
        |-> o_chan_tx[0] == '0) else $error("tx not idle");
    a_jam_both: assert property (up && o_chan_port_map[0][6]
        && o_chan_port_map[1][6] && ma[1:0] != mb[1:0] && !ma[1] && !mb[1]
        && |i_chan_col |=> o_chan_jam == 2'h3)
        else $error("jam");
    a_link_own: assert property (up |-> o_link_indicator == $past(i_chan_link))
        else $error("link");
endmodule // crossbar_props
bind port_crossbar crossbar_props u_props (.i_mclk, .i_nrst, .o_port_rx,
    .i_chan_rx, .o_chan_tx, .i_chan_col, .o_chan_jam, .i_chan_link,
    .o_link_indicator, .o_chan_port_map);
`default_nettype wire

//--- tb/mac_partner.sv
// MAC model: one MII transmit stream per port, a held nibble each.
// Assumes the core clock, as in single clock mode.
`timescale 1ns/1ns
`default_nettype none
module mac_partner (
    input wire logic i_mclk,
    input wire logic [1:0] i_go,
    input wire logic [1:0][3:0] i_nib,
    output var crossbar_pkg::mii_word_s [1:0] o_tx
);
    // Idle data toggles so a stale nibble never passes for data
    initial o_tx = '0;
    always @(posedge i_mclk)
        for (int p = 0; p < 2; p++)
            o_tx[p] <= {i_go[p], i_go[p], i_go[p] ? i_nib[p] : ~o_tx[p].data};
endmodule // mac_partner
`default_nettype wire

//--- tb/dual_mii_port_crossbar_bench.sv
// Bench: management frames, routing scenarios, buffer stall, straps.
// Assumes port_crossbar, mac_partner and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module dual_mii_port_crossbar_bench;
    localparam logic [4:0] PA = crossbar_pkg::PHY_BASE;
    localparam logic [4:0] PB = PA + 5'h01;
    localparam logic [4:0] RM = crossbar_pkg::REG_PORT_MAP;
    logic i_mclk, i_nrst, mdc, mdo_drv, ext;
    logic [1:0] go, rdy, col, crs, pd, lnk, an, fx;
    logic [1:0][3:0] nib;
    logic [15:0] rd;
    int error_cnt, checks_done, t;
    crossbar_pkg::mii_word_s [1:0] crx;
    wire crossbar_pkg::mii_word_s [1:0] ptx, prx, ctx;
    wire [1:0] pcrs, oen, sr, jam, li, can, cfx;
    wire [1:0][15:0] bas, pm;
    wire mdo, mdoe, mdio_w;
    // The bench driver mdo_drv sets the line whenever the block leaves it
    assign mdio_w = mdoe ? mdo_drv : mdo;
    mac_partner MAC (.i_mclk(i_mclk), .i_go(go), .i_nib(nib), .o_tx(ptx));
    port_crossbar DUT (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_mdc(mdc),
        .i_mdio(mdio_w), .o_mdio(mdo), .o_mdio_oe_n(mdoe), .i_port_tx(ptx),
        .o_port_rx(prx), .o_port_crs(pcrs), .o_port_col(), .o_port_oe_n(oen),
        .i_chan_rx(crx), .i_chan_crs(crs), .i_chan_col(col),
        .i_chan_pwr_down(pd), .i_chan_energy_idle(2'b00), .i_chan_link(lnk),
        .o_chan_tx(ctx), .i_chan_tx_ready(rdy), .o_chan_src_ready(sr),
        .o_chan_jam(jam), .o_link_indicator(li), .i_extender_strap(ext),
        .i_rmii_strap(1'b0), .i_autoneg_strap(an), .i_fiber_mode_strap(fx),
        .o_chan_autoneg(can), .o_chan_fiber(cfx), .o_chan_basic(bas),
        .o_chan_port_map(pm));
    task automatic wt(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic chk(input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
        end
    endtask
    function automatic logic [15:0] w2(input logic [5:0] b, a);
        return {4'h0, b, a};
    endfunction
    task tend;
        t++;
        $display("test %0d done", t);
    endtask
    // Full preamble on every frame: slower, but never out of step
    task automatic xf(input logic [1:0] op, input logic [4:0] p, r,
        input logic [15:0] d);
        logic [63:0] f;
        f = {32'hFFFF_FFFF, 2'h1, op, p, r, 1'b1, op[1], d};
        for (int i = 63; i >= 0; i--) begin
            mdc <= 1'b0;
            mdo_drv <= f[i];
            wt(5);
            mdc <= 1'b1;
            rd = {rd[14:0], mdio_w};
            wt(5);
        end
    endtask
    task automatic m2(input logic [15:0] a, b);
        xf(2'h1, PA, RM, a);
        xf(2'h1, PB, RM, b);
        wt(8);
    endtask
    task print_verdict;
        $display("%0d checks, %0d mismatches", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        i_mclk = 0;
        forever #4 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (30000) @(posedge i_mclk);
        error_cnt++;
        print_verdict;
    end
    initial begin
        {i_nrst, mdc, mdo_drv, ext, go, col, crs, pd, lnk, an, fx} = '0;
        {rdy, nib, crx} = {2'b11, 4'hA, 4'h5, 6'h3C, 6'h33};
        t = 0;
        wt(12);
        i_nrst <= 1'b1;
        wt(20);
        chk(pm[0] | pm[1] | bas[0] | bas[1], 16'h0000);
        go <= 2'b11;
        wt(8);
        chk({4'h0, ctx}, w2(6'h3A, 6'h35));
        chk({4'h0, prx}, w2(6'h3C, 6'h33));
        tend;
        m2(16'h0A00, 16'h0A00);
        chk({4'h0, ctx}, w2(6'h35, 6'h3A));
        chk({4'h0, prx}, w2(6'h33, 6'h3C));
        xf(2'h2, PB, RM, 16'hFFFF);
        chk(rd, 16'h0A00);
        xf(2'h2, PA, 5'h03, 16'hFFFF);
        chk(rd, 16'h0000);
        tend;
        m2(16'h1CC0, 16'h1CC0);
        chk({4'h0, ctx}, w2(6'h33, 6'h3C));
        chk({4'h0, prx}, 16'h0000);
        m2(16'h0040, 16'h0240);
        chk({4'h0, ctx}, w2(6'h35, 6'h35));
        crs <= 2'b10;
        col <= 2'b10;
        wt(4);
        chk({14'h0, pcrs}, 16'h0001);
        chk({14'h0, jam}, 16'h0003);
        col <= 2'b00;
        m2(16'h0200, 16'h0000);
        chk({4'h0, ctx}, w2(6'h3A, 6'h3A));
        m2(16'h0820, 16'h0820);
        chk({14'h0, pcrs}, 16'h0001);
        tend;
        m2(16'h1000, 16'h1800);
        chk({4'h0, prx}, w2(6'h33, 6'h33));
        m2(16'h1E00, 16'h0000);
        chk({4'h0, prx}, w2(6'h3C, 6'h00));
        chk({4'h0, ctx}, w2(6'h3A, 6'h00));
        tend;
        m2(16'h0000, 16'h0000);
        rdy <= 2'b00;
        wt(8);
        chk({14'h0, sr}, 16'h0000);
        chk({4'h0, ctx}, w2(6'h3A, 6'h35));
        go <= 2'b00;
        rdy <= 2'b11;
        wt(6);
        chk({2'h0, sr, ctx}, 16'h3000);
        xf(2'h1, PA, 5'h00, 16'h0400);
        wt(3);
        chk({14'h0, oen}, 16'h0001);
        pd <= 2'b10;
        lnk <= 2'b01;
        wt(3);
        chk({12'h0, oen, li}, 16'h000D);
        tend;
        i_nrst <= 1'b0;
        {ext, fx, an} <= 5'b10110;
        wt(12);
        i_nrst <= 1'b1;
        wt(20);
        chk(pm[0] & pm[1], 16'h1CC0);
        chk({12'h0, cfx, can}, 16'h0006);
        tend;
        print_verdict;
    end
endmodule // dual_mii_port_crossbar_bench
`default_nettype wire
